// ### common/mfp_pkg.sv
// Package of offsets, field positions, codes and timing counts for the multifunction pin block.
package mfp_pkg;
    // Register offsets (register-map index, 16-bit words).
    localparam logic [7:0]  MFP_STATUS_ADDR  = 8'h23;   // Compare and shutdown status.
    localparam logic [7:0]  MFP_CONFIG_ADDR  = 8'h24;   // Pin function configuration.
    localparam logic [15:0] MFP_CONFIG_RESET = 16'h0000; // Configuration reset value.
    // Configuration field positions.
    localparam int CFG_INPUT_EN    = 0;   // Input enable bit.
    localparam int CFG_FUNC_LO     = 1;   // Input function low bit.
    localparam int CFG_MASK_LO     = 5;   // Channel mask low bit.
    localparam int CFG_SEL_LO      = 9;   // Output select low bit.
    localparam int CFG_OUTPUT_EN   = 13;  // Output enable bit.
    localparam int CFG_HOLD_EN     = 14;  // Low-power hold enable bit.
    localparam int CFG_FILTER_ON   = 15;  // Glitch filter enable bit.
    // Status field positions.
    localparam int STS_SYNC_LO     = 0;   // Synchronized comparator outputs.
    localparam int STS_WIN_LO      = 4;   // Window comparator outputs.
    localparam int STS_SHUTDOWN    = 8;   // Safe-shutdown flag.
    // Output select codes.
    localparam logic [3:0] SEL_MEM_BUSY = 4'h1;  // Memory busy.
    localparam logic [3:0] SEL_CH0_BUSY = 4'h4;  // Channel 0 busy.
    localparam logic [3:0] SEL_CH1_BUSY = 4'h5;  // Channel 1 busy.
    localparam logic [3:0] SEL_CH23_BSY = 4'h7;  // Channel 2 or 3 busy (shared code).
    localparam logic [3:0] SEL_WIN0     = 4'h8;  // Window comparator 0.
    localparam logic [3:0] SEL_WIN3     = 4'hb;  // Window comparator 3.
    // Input function codes.
    typedef enum logic [3:0] {
        MFP_FN_HOLD     = 4'b0000,
        MFP_FN_DUMP     = 4'b0010,
        MFP_FN_CURRENT  = 4'b0011,
        MFP_FN_VOLTAGE  = 4'b0100,
        MFP_FN_SHUTDOWN = 4'b0101,
        MFP_FN_CLEAR    = 4'b0111,
        MFP_FN_LOAD     = 4'b1000,
        MFP_FN_WAVE     = 4'b1001,
        MFP_FN_MARGIN   = 4'b1010,
        MFP_FN_RESET    = 4'b1011,
        MFP_FN_NVM      = 4'b1100,
        MFP_FN_LOCK     = 4'b1101
    } mfp_func_t;
    // Glitch filter: pulses shorter than this are rejected.
    localparam int          FILTER_NS     = 200;
    localparam int          CLK_PERIOD_NS = 50;
    localparam logic [3:0]  FILTER_CYCLES = 4'((FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ### hdl/mfp_filter.sv
// Glitch filter that passes a level only after it has stood for a set number of cycles.
`timescale 1ns/100ps
module mfp_filter
    import mfp_pkg::*;
(
    input  wire logic ref_clk_i,  // Clock.
    input  wire logic rst_i,      // Asynchronous reset, active high.
    input  wire logic ce_i,       // Clock enable.
    input  wire logic bypass_i,   // High to pass the input straight through.
    input  wire logic level_i,    // Synchronized level.
    output logic      level_o     // Filtered level.
);
    logic [3:0] count;           // Cycles the input has differed from the output.
    logic       held;            // Filtered value.
    wire        differs = (level_i != held);
    wire        settled = (count == FILTER_CYCLES - 4'h1);

    // The held value follows the input once it has stood long enough.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 4'h0;
            held  <= 1'b1;
        end else if (ce_i) begin
            count <= (differs && !settled) ? count + 4'h1 : 4'h0;
            if (differs && settled) begin
                held <= level_i;
            end
        end
    end

    // Bypass gives the faster path with no added delay.
    assign level_o = bypass_i ? level_i : held;
endmodule

// ### hdl/mfp_pin_status.sv
// Multifunction pin logic with comparator and safe-shutdown status register.
//
// Contract
// [R1] Shutdown flag sets, holds, clears on read.
// [R2] Status 7:4 show window comparators, latched optionally.
// [R3] Status 3:0 show synchronized comparator outputs.
// [R4] Config bit 15 inserts glitch filter.
// [R5] Config bit 14 enables low-power hold.
// [R6] Config bit 13 enables pin output driver.
// [R7] Config bit 0 enables pin input functions.
// [R8] Bits 12:9 choose driven status signal.
// [R9] Bits 8:5 enable channels one bit each.
// [R10] Global codes device-wide, channel codes masked.
// [R11] Code 0000 edges enter, leave hold.
// [R12] Code 0010 falling edge starts fault dump.
// [R13] Code 0011 edges switch current outputs.
// [R14] Code 0100 edges switch voltage outputs.
// [R15] Code 0101 falling edge starts safe shutdown.
// [R16] Code 0111 low level asserts clear.
// [R17] Code 1000 falling edge loads masked channels.
// [R18] Code 1001 edges stop, start waveforms.
// [R19] Code 1010 edges trigger margin low, high.
// [R20] Code 1011 edges reset and release device.
// [R21] Code 1100 edges allow, block memory programming.
// [R22] Code 1101 edges unlock, lock register map.
// [R23] Compare reset clears latched comparator outputs.
// [R24] Channel busy bits mappable to pin.
// [R25] Pin synchronized, filtered, then edge detected.
// [R26] Unknown codes idle; read never loses set.
`timescale 1ns/100ps
module mfp_pin_status
    import mfp_pkg::*;
(
    input  wire logic        ref_clk_i,           // Clock, 20 MHz.
    input  wire logic        rst_i,               // Asynchronous reset, active high.
    input  wire logic        ce_i,                // Clock enable; low freezes all state.
    // Register port.
    input  wire logic [7:0]  reg_addr_i,          // Register address.
    input  wire logic        reg_wr_i,            // Write strobe.
    input  wire logic        reg_rd_i,            // Read strobe.
    input  wire logic [15:0] reg_wdata_i,         // Write data.
    output logic [15:0]      reg_rdata_o,         // Read data, valid the cycle after the strobe.
    // Pin.
    input  wire logic        pin_i,               // Pin level from the pad.
    output logic             pin_o,               // Pin drive value.
    output logic             pin_oe_o,            // High while the pin is driven.
    // Status sources.
    input  wire logic        memory_busy_i,       // Memory engine busy.
    input  wire logic [3:0]  chan_busy_i,         // Per-channel busy.
    input  wire logic [3:0]  compare_raw_i,       // Raw comparator outputs.
    input  wire logic [3:0]  window_raw_i,        // Raw window comparator outputs.
    input  wire logic        window_latch_en_i,   // Latch window results when high.
    input  wire logic [3:0]  compare_hold_clear_i,// Comparator reset command pulses.
    input  wire logic        shutdown_active_i,   // Safe shutdown in progress.
    // Actions.
    output logic             hold_mode_o,         // Device in low-power hold.
    output logic             input_hold_en_o,     // Low-power hold enabled for pin input.
    output logic             fault_dump_o,        // Fault dump pulse.
    output logic [3:0]       current_output_dn_o, // Current outputs powered down.
    output logic [3:0]       voltage_output_dn_o, // Voltage outputs powered down.
    output logic             shutdown_start_o,    // Safe shutdown start pulse.
    output logic             clear_outputs_o,     // Clear asserted.
    output logic [3:0]       sync_load_update_o,  // Load update pulses.
    output logic [3:0]       wave_run_o,          // Waveform generation running.
    output logic [3:0]       margin_low_o,        // Margin-low pulses.
    output logic [3:0]       margin_high_o,       // Margin-high pulses.
    output logic             device_reset_o,      // Device held in reset.
    output logic             nvm_write_allow_o,   // Memory programming allowed.
    output logic             map_locked_o         // Register map locked.
);
    logic [15:0] config_reg;       // Pin function configuration.
    logic        shutdown_flag;    // Sticky safe-shutdown flag.
    logic [3:0]  win_latched;      // Latched window comparator results.
    logic [3:0]  cmp_s1, cmp_s2, cmp_s3;  // Comparator synchronizer stages.
    logic [3:0]  cmp_sync;         // Agreed comparator level.
    logic        pin_s1, pin_s2, pin_s3;  // Pin synchronizer stages.
    logic        pin_sync;         // Agreed pin level.
    logic        pin_prev;         // Filtered pin one cycle ago.
    logic        pin_filt;         // Filtered pin level.

    // Configuration fields.
    wire        filter_on   = config_reg[CFG_FILTER_ON];
    wire        output_en   = config_reg[CFG_OUTPUT_EN];
    wire        input_en    = config_reg[CFG_INPUT_EN];
    wire [3:0]  out_sel     = config_reg[CFG_SEL_LO +: 4];
    wire [3:0]  chan_mask   = config_reg[CFG_MASK_LO +: 4];
    wire [3:0]  func        = config_reg[CFG_FUNC_LO +: 4];

    // Register decode.
    wire        wr_config   = reg_wr_i && (reg_addr_i == MFP_CONFIG_ADDR);
    wire        rd_status   = reg_rd_i && (reg_addr_i == MFP_STATUS_ADDR);
    wire        rd_config   = reg_rd_i && (reg_addr_i == MFP_CONFIG_ADDR);

    // Window comparator view: latched or live.
    wire [3:0]  win_view    = window_latch_en_i ? win_latched : window_raw_i;  // [R2]
    wire [15:0] status_word = {7'h00, shutdown_flag, win_view, cmp_sync};      // [R1] [R2] [R3]

    // Edge detection on the filtered pin, gated by input enable.
    wire        fall        = input_en && pin_prev && !pin_filt;  // [R7] [R25]
    wire        rise        = input_en && !pin_prev && pin_filt;  // [R7] [R25]
    wire        is_fn_hold  = (func == MFP_FN_HOLD);
    wire        is_fn_cur   = (func == MFP_FN_CURRENT);
    wire        is_fn_volt  = (func == MFP_FN_VOLTAGE);
    wire        is_fn_wave  = (func == MFP_FN_WAVE);
    wire        is_fn_marg  = (func == MFP_FN_MARGIN);
    wire        is_fn_rst   = (func == MFP_FN_RESET);
    wire        is_fn_nvm   = (func == MFP_FN_NVM);
    wire        is_fn_lock  = (func == MFP_FN_LOCK);
    wire [3:0]  fall_mask   = {4{fall}} & chan_mask;  // [R9] [R10]
    wire [3:0]  rise_mask   = {4{rise}} & chan_mask;  // [R9] [R10]
    wire        shut_trig   = fall && (func == MFP_FN_SHUTDOWN);  // [R15]
    wire [3:0]  cmp_moving  = cmp_s2 ^ cmp_s3;  // Stages two and three still differ.

    // Output multiplexer for the pin drive value.
    logic       next_pin;
    always_comb begin
        next_pin = 1'b0;
        case (out_sel)  // [R8] [R24]
            SEL_MEM_BUSY: next_pin = memory_busy_i;
            SEL_CH0_BUSY: next_pin = chan_busy_i[0];
            SEL_CH1_BUSY: next_pin = chan_busy_i[1];
            SEL_CH23_BSY: next_pin = chan_busy_i[2] | chan_busy_i[3];
            default: begin
                if (out_sel >= SEL_WIN0 && out_sel <= SEL_WIN3) begin
                    next_pin = win_view[out_sel[1:0]];
                end
            end
        endcase
    end

    // Configuration register and read data.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            config_reg  <= MFP_CONFIG_RESET;
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            if (wr_config) begin
                config_reg <= reg_wdata_i;
            end
            reg_rdata_o <= rd_status ? status_word : (rd_config ? config_reg : 16'h0000);
        end
    end

    // Safe-shutdown flag: a new set wins over the read clear.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shutdown_flag <= 1'b0;
        end else if (ce_i) begin
            if (shut_trig || shutdown_active_i) begin
                shutdown_flag <= 1'b1;  // [R1] [R26]
            end else if (rd_status) begin
                shutdown_flag <= 1'b0;  // [R1]
            end
        end
    end

    // Window latches set on a result and clear on the comparator reset command.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_latched <= 4'h0;
        end else if (ce_i) begin
            win_latched <= (win_latched & ~compare_hold_clear_i) | window_raw_i;  // [R2] [R23]
        end
    end

    // Comparator synchronizers: a change counts when stages two and three agree.
    // While they differ the agreed level holds; a compare reset drops it to zero.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_s1   <= 4'h0;
            cmp_s2   <= 4'h0;
            cmp_s3   <= 4'h0;
            cmp_sync <= 4'h0;
        end else if (ce_i) begin
            cmp_s1   <= compare_raw_i;
            cmp_s2   <= cmp_s1;
            cmp_s3   <= cmp_s2;
            cmp_sync <= ((cmp_sync & cmp_moving) | (cmp_s2 & cmp_s3))
                        & ~compare_hold_clear_i;  // [R3] [R23]
        end
    end

    // Pin synchronizer; idles high so reset does not look like a falling edge.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1   <= 1'b1;
            pin_s2   <= 1'b1;
            pin_s3   <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else if (ce_i) begin
            pin_s1   <= pin_i;
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_sync <= pin_s3;  // [R25]
            end
            pin_prev <= pin_filt;
        end
    end

    // Glitch filter sits after the synchronizer.
    mfp_filter u_filter (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .bypass_i  (!filter_on),  // [R4]
        .level_i   (pin_sync),
        .level_o   (pin_filt)
    );

    // Pin drive and mode outputs.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_o           <= 1'b0;
            pin_oe_o        <= 1'b0;
            input_hold_en_o <= 1'b0;
            clear_outputs_o <= 1'b0;
        end else if (ce_i) begin
            pin_o           <= output_en & next_pin;               // [R8]
            pin_oe_o        <= output_en;                          // [R6]
            input_hold_en_o <= config_reg[CFG_HOLD_EN];            // [R5]
            clear_outputs_o <= input_en && (func == MFP_FN_CLEAR) && !pin_filt;  // [R16]
        end
    end

    // One-cycle action pulses; unlisted codes match nothing.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_dump_o       <= 1'b0;
            shutdown_start_o   <= 1'b0;
            sync_load_update_o <= 4'h0;
            margin_low_o       <= 4'h0;
            margin_high_o      <= 4'h0;
        end else if (ce_i) begin
            fault_dump_o       <= fall && (func == MFP_FN_DUMP);              // [R12] [R26]
            shutdown_start_o   <= shut_trig;                                  // [R15]
            sync_load_update_o <= (func == MFP_FN_LOAD) ? fall_mask : 4'h0;  // [R17]
            margin_low_o       <= is_fn_marg ? fall_mask : 4'h0;             // [R19]
            margin_high_o      <= is_fn_marg ? rise_mask : 4'h0;             // [R19]
        end
    end

    // Level-held actions set by one edge and released by the other.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_mode_o         <= 1'b0;
            current_output_dn_o <= 4'h0;
            voltage_output_dn_o <= 4'h0;
            wave_run_o          <= 4'h0;
            device_reset_o      <= 1'b0;
            nvm_write_allow_o   <= 1'b0;
            map_locked_o        <= 1'b0;
        end else if (ce_i) begin
            if (is_fn_hold && fall) hold_mode_o <= 1'b1;          // [R11]
            if (is_fn_hold && rise) hold_mode_o <= 1'b0;          // [R11]
            if (is_fn_cur) begin
                current_output_dn_o <= (current_output_dn_o | fall_mask) & ~rise_mask;  // [R13]
            end
            if (is_fn_volt) begin
                voltage_output_dn_o <= (voltage_output_dn_o | fall_mask) & ~rise_mask;  // [R14]
            end
            if (is_fn_wave) begin
                wave_run_o <= (wave_run_o & ~fall_mask) | rise_mask;  // [R18]
            end
            if (is_fn_rst && fall) device_reset_o <= 1'b1;        // [R20]
            if (is_fn_rst && rise) device_reset_o <= 1'b0;        // [R20]
            if (is_fn_nvm && fall) nvm_write_allow_o <= 1'b1;     // [R21]
            if (is_fn_nvm && rise) nvm_write_allow_o <= 1'b0;     // [R21]
            if (is_fn_lock && fall) map_locked_o <= 1'b0;         // [R22]
            if (is_fn_lock && rise) map_locked_o <= 1'b1;         // [R22]
        end
    end

    // Checks on the guarded behaviour.
    sequence s_status_read;
        ce_i && rd_status && !shut_trig && !shutdown_active_i;
    endsequence

    a_shutdown_read_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R1]
        s_status_read |=> !shutdown_flag) else $error("shutdown flag not cleared");
    a_shutdown_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R26]
        ce_i && shut_trig |=> shutdown_flag) else $error("shutdown trigger lost");
    a_output_enable_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R6]
        ce_i |=> pin_oe_o == $past(output_en)) else $error("pin enable wrong");
    a_pin_undriven_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R6]
        !pin_oe_o |-> !pin_o) else $error("pin value without enable");
    a_input_disabled_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R7]
        ce_i && !input_en |=> !fault_dump_o && !shutdown_start_o) else $error("action while off");
    a_load_masked_chan: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R17]
        ce_i |=> (sync_load_update_o & ~$past(chan_mask)) == 4'h0) else $error("load unmasked");
    a_dump_needs_fall: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R12]
        fault_dump_o |-> $past(pin_prev) && !$past(pin_filt)) else $error("dump without fall");
    a_margin_pair_excl: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R19]
        (margin_low_o & margin_high_o) == 4'h0) else $error("margin both");
    a_filter_bypass_path: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R4]
        !filter_on |-> pin_filt == pin_sync) else $error("bypass not direct");

    // An agreed comparator level must reach the status bits one cycle later.
    a_compare_sync_agree: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R3]
        ce_i && (cmp_s2 == cmp_s3) && (compare_hold_clear_i == 4'h0)
        |=> cmp_sync == $past(cmp_s3)) else $error("compare sync wrong");
endmodule

// ### dv/mfp_board_drv.sv
// Board-side model that drives the multifunction pin, with a pull-up when released.
`timescale 1ns/100ps
module mfp_board_drv #(
    parameter int PULSE_CYCLES = 12  // Length of a low pulse, in clock cycles.
) (
    input  wire logic ref_clk_i,      // Clock.
    input  wire logic drive_en_i,     // High while the board holds a level on the pin.
    input  wire logic drive_level_i,  // Level the board holds.
    input  wire logic pulse_i,        // One-cycle request for a low pulse.
    input  wire logic dev_pin_i,      // Device drive value.
    input  wire logic dev_oe_i,       // Device drive enable.
    output logic      pin_o           // Resolved pin level.
);
    int pulse_left = 0;  // Cycles of low pulse still to drive.
    // The pulse always ends by itself, so a reset request is never left standing.
    always @(posedge ref_clk_i) begin
        if (pulse_i) begin
            pulse_left <= PULSE_CYCLES;
        end else if (pulse_left > 0) begin
            pulse_left <= pulse_left - 1;
        end
    end
    // The device wins while it drives; a released pin floats up to the pull-up level.
    assign pin_o = dev_oe_i ? dev_pin_i : (pulse_left > 0) ? 1'b0 :
                   drive_en_i ? drive_level_i : 1'b1;
endmodule

// ### dv/mfp_pin_status_tb.sv
// Self-checking testbench for the multifunction pin and status block.
`timescale 1ns/100ps
module mfp_pin_status_tb;
    import mfp_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, drv_en = 1'b0, drv_lv = 1'b1;
    logic pulse = 1'b0, mem_busy = 1'b0, win_latch = 1'b0, pin, pin_o, pin_oe, shut_act = 1'b0;
    logic [7:0]  addr = 8'h00;  // Register address.
    logic [15:0] wdata = 16'h0000, rdata, got;  // Write data, read data, captured value.
    logic [3:0]  ch_busy = 4'h0, cmp_raw = 4'h0, win_raw = 4'h0, hold_clr = 4'h0;
    logic hold_mode, hold_en, dump, shut, clr, dev_rst, nvm_ok, locked;
    logic [3:0]  cur_dn, volt_dn, load, wave, mlo, mhi;  // Per-channel actions.
    int fail_count = 0, samples_checked = 0, shut_pulses = 0, dump_pulses = 0;
    logic [3:0]  load_seen = 4'h0, mlo_seen = 4'h0, mhi_seen = 4'h0;  // Gathered action pulses.
    logic [3:0] sel_code [9] = '{4'h1, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'h2};
    logic       sel_exp  [9] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    // The clock toggles every half period of 25 ns.
    always #25 ref_clk = ~ref_clk;
    // Counts and gathers one-cycle pulses so that one edge giving two shows up.
    always @(posedge ref_clk) begin
        shut_pulses <= shut_pulses + int'(shut);
        dump_pulses <= dump_pulses + int'(dump);
        if (!rst) begin
            load_seen <= load_seen | load;
            mlo_seen  <= mlo_seen | mlo;
            mhi_seen  <= mhi_seen | mhi;
        end
    end
    mfp_pin_status i_mfp_pin_status (.ref_clk_i(ref_clk), .rst_i(rst), .ce_i(1'b1),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .pin_i(pin), .pin_o(pin_o), .pin_oe_o(pin_oe),
        .memory_busy_i(mem_busy), .chan_busy_i(ch_busy), .compare_raw_i(cmp_raw),
        .window_raw_i(win_raw), .window_latch_en_i(win_latch),
        .compare_hold_clear_i(hold_clr), .shutdown_active_i(shut_act), .hold_mode_o(hold_mode),
        .input_hold_en_o(hold_en), .fault_dump_o(dump), .current_output_dn_o(cur_dn),
        .voltage_output_dn_o(volt_dn), .shutdown_start_o(shut), .clear_outputs_o(clr),
        .sync_load_update_o(load), .wave_run_o(wave), .margin_low_o(mlo),
        .margin_high_o(mhi), .device_reset_o(dev_rst), .nvm_write_allow_o(nvm_ok),
        .map_locked_o(locked));
    mfp_board_drv #(.PULSE_CYCLES(12)) i_mfp_board_drv (.ref_clk_i(ref_clk),
        .drive_en_i(drv_en), .drive_level_i(drv_lv), .pulse_i(pulse), .dev_pin_i(pin_o),
        .dev_oe_i(pin_oe), .pin_o(pin));
    // Writes one register; the strobe stands for exactly one taken edge.
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Reads one register; data is settled just after the edge that takes the strobe.
    task automatic reg_read(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a; rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    // Compares a 16-bit register value.
    task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t reg got %h exp %h", $time, g, e);
        end
    endtask
    // Compares a port value of up to four bits.
    task automatic chk_port(input logic [3:0] g, input logic [3:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t port got %h exp %h", $time, g, e);
        end
    endtask
    // Holds a pin level long enough for the filtered path to act.
    task automatic set_pin(input logic lv);
        @(posedge ref_clk);
        drv_en <= 1'b1; drv_lv <= lv;
        repeat (15) @(posedge ref_clk);
        #1;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog that cuts a hang short well after the tests should be done.
    initial begin
        #(50 * 20000);
        fail_count++;
        finish_test();
    end
    // Main sequence of tests.
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        reg_read(MFP_CONFIG_ADDR); chk_reg(got, MFP_CONFIG_RESET);
        reg_write(8'h30, 16'hffff); reg_write(MFP_STATUS_ADDR, 16'hffff);
        reg_read(MFP_CONFIG_ADDR); chk_reg(got, 16'h0000);
        reg_read(8'h30); chk_reg(got, 16'h0000);
        reg_write(MFP_CONFIG_ADDR, 16'h4000); reg_read(MFP_CONFIG_ADDR);
        chk_reg(got, 16'h4000);
        chk_port({3'h0, hold_en}, 4'h1);
        cmp_raw <= 4'b1010; repeat (6) @(posedge ref_clk);
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h000f, 16'h000a);
        cmp_raw <= 4'b0000; win_latch <= 1'b1; win_raw <= 4'b1001;
        @(posedge ref_clk) win_raw <= 4'b0000;
        repeat (6) @(posedge ref_clk);
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h00f0, 16'h0090);
        chk_reg(got & 16'h000f, 16'h0000);
        hold_clr <= 4'b0001; @(posedge ref_clk) hold_clr <= 4'b0000;
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h00f0, 16'h0080);
        reg_write(MFP_CONFIG_ADDR, 16'h000a); set_pin(1'b0); set_pin(1'b1);
        chk_port(4'(shut_pulses), 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h000b); set_pin(1'b0);
        chk_port(4'(shut_pulses), 4'h1);
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h0100, 16'h0100);
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h0100, 16'h0000);
        shut_act <= 1'b1; reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h0100, 16'h0100);
        reg_read(MFP_STATUS_ADDR); shut_act <= 1'b0; chk_reg(got & 16'h0100, 16'h0100);
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h0100, 16'h0100);
        reg_read(MFP_STATUS_ADDR); chk_reg(got & 16'h0100, 16'h0000);
        reg_write(MFP_CONFIG_ADDR, 16'h80a7); set_pin(1'b1);
        @(posedge ref_clk) drv_lv <= 1'b0;
        repeat (3) @(posedge ref_clk);
        drv_lv <= 1'b1;
        set_pin(1'b1); chk_port(cur_dn, 4'h0);
        set_pin(1'b0); chk_port(cur_dn, 4'b0101);
        set_pin(1'b1); chk_port(cur_dn, 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h000f); set_pin(1'b0);
        chk_port({3'h0, clr}, 4'h1);
        set_pin(1'b1); chk_port({3'h0, clr}, 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h0001); set_pin(1'b0);
        chk_port({3'h0, hold_mode}, 4'h1);
        set_pin(1'b1); chk_port({3'h0, hold_mode}, 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h0005); set_pin(1'b0); set_pin(1'b1);
        chk_port(4'(dump_pulses), 4'h1);
        reg_write(MFP_CONFIG_ADDR, 16'h0069); set_pin(1'b0);
        chk_port(volt_dn, 4'b0011);
        set_pin(1'b1); chk_port(volt_dn, 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h00d1); set_pin(1'b0); set_pin(1'b1);
        chk_port(load_seen, 4'b0110);
        reg_write(MFP_CONFIG_ADDR, 16'h01f3); set_pin(1'b0); set_pin(1'b1);
        chk_port(wave, 4'hf);
        set_pin(1'b0); chk_port(wave, 4'h0);
        set_pin(1'b1); reg_write(MFP_CONFIG_ADDR, 16'h0135); set_pin(1'b0);
        chk_port(mlo_seen, 4'b1001);
        chk_port(mhi_seen, 4'h0);
        set_pin(1'b1); chk_port(mhi_seen, 4'b1001);
        reg_write(MFP_CONFIG_ADDR, 16'h0019); set_pin(1'b0);
        chk_port({3'h0, nvm_ok}, 4'h1);
        set_pin(1'b1); chk_port({3'h0, nvm_ok}, 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h001b); set_pin(1'b0); set_pin(1'b1);
        chk_port({3'h0, locked}, 4'h1);
        set_pin(1'b0); chk_port({3'h0, locked}, 4'h0);
        set_pin(1'b1);
        reg_write(MFP_CONFIG_ADDR, 16'h0017); drv_en <= 1'b0;
        @(posedge ref_clk) pulse <= 1'b1;
        @(posedge ref_clk) pulse <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 chk_port({3'h0, dev_rst}, 4'h1);
        repeat (15) @(posedge ref_clk);
        #1 chk_port({3'h0, dev_rst}, 4'h0);
        reg_write(MFP_CONFIG_ADDR, 16'h0000); drv_en <= 1'b0;
        mem_busy <= 1'b1; ch_busy <= 4'b1010; win_latch <= 1'b0; win_raw <= 4'b0100;
        for (int k = 0; k < 9; k++) begin
            reg_write(MFP_CONFIG_ADDR, 16'h2000 | {3'h0, sel_code[k], 9'h000});
            repeat (3) @(posedge ref_clk);
            #1 chk_port({2'h0, pin_oe, pin_o}, {2'h0, 1'b1, sel_exp[k]});
        end
        reg_write(MFP_CONFIG_ADDR, 16'h0200); repeat (3) @(posedge ref_clk);
        #1 chk_port({3'h0, pin_oe}, 4'h0);
        finish_test();
    end
endmodule
